//--- design/adc_ctl_pkg.sv
// Function
// - writing start bit begins sampling; hardware clears it when conversion ends
// - power enable one powers the converter, zero gates it off
// - crystal mode rate codes give 74.6K, 37.4K, 18.7K, 9.3K samples per second
// - rc modes: rate is oscillator over 4, over two to the code, over 12
// - channel code 000..111 selects analog inputs 1..8 in order
// - ch7 switch: 0 leaves port 9 pin 2 general, 1 makes it input 7
// - ch8 switch: 0 leaves port 9 pin 3 general, 1 makes it input 8
// - inputs 1,2 on port 9 pins 0,1; inputs 3-6 on port 6 pins 2-5
// - one 10-bit successive approximation converter behind an 8-way mux
// - completion sets done flag, cleared by software; irq only when masked in
// - low 8 result bits in data register, high 2 in bits 4 and 5
// - each conversion takes 12 converter clock cycles
// - started with mask 0: convert continuously, keep start bit, no done flag
package adc_ctl_pkg;
    localparam logic [2:0] ADDR_PIN_SWITCH = 3'h0;
    localparam logic [2:0] ADDR_CONV_CTRL = 3'h1;
    localparam logic [2:0] ADDR_RESULT_LO = 3'h2;
    localparam logic [2:0] ADDR_RESULT_HI = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
    localparam int START_BIT = 0;
    localparam int POWER_BIT = 2;
    localparam int RATE_LSB = 3;
    localparam int CHAN_LSB = 5;
    localparam int CH7_BIT = 0;
    localparam int CH8_BIT = 1;
    localparam int DONE_BIT = 5;
    localparam int RES_HI_LSB = 4;
    localparam logic [7:0] CONV_CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hfd;
    localparam logic [7:0] PIN_WMASK = 8'h4b;
    localparam logic [3:0] CONV_CYCLES = 4'h0c;
    // crystal mode: clk_sys 40 MHz, per-step divide giving 12 steps/sample
    // 40e6/(12*74.6e3)=44.7 -> 45 (74.07K), halves/doubles for slower codes
    localparam int CLK_HZ = 40000000;
    localparam int XTAL_RATE0_HZ = 74600;
    localparam logic [15:0] XTAL_DIV0 =
        16'((CLK_HZ + 12 * XTAL_RATE0_HZ - 1) / (12 * XTAL_RATE0_HZ));
    // rc modes: per step divide is 4 * 2^code of the oscillator
    localparam logic [15:0] RC_DIV0 = 16'h0004;
endpackage : adc_ctl_pkg

//--- design/adc_conversion_control.sv
`timescale 1ns/1ps
module adc_conversion_control (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // oscillator mode straps
    input wire logic internal_rc_osc_mode,
    input wire logic external_rc_osc_mode,
    input wire logic osc_tick,
    // analog front end
    output logic conv_power_enable,
    output logic [2:0] mux_select,
    output logic sample_hold,
    output logic [9:0] sar_trial,
    input wire logic comparator_hi,
    // pin switches
    output logic [7:0] analog_pin_enable,
    // interrupt
    output logic irq
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } conv_state_e;

    conv_state_e state_ff, nxt_state;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] pin_ff, nxt_pin;
    logic [5:0] p6_switch_ff, nxt_p6_switch;
    logic [7:0] res_lo_ff, nxt_res_lo;
    logic [1:0] res_hi_ff, nxt_res_hi;
    logic done_ff, nxt_done;
    logic mask_ff, nxt_mask;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [2:0] chan_ff, nxt_chan;
    logic [1:0] rate_ff, nxt_rate;
    logic [15:0] div_ff, nxt_div;
    logic [3:0] step_ff, nxt_step;
    logic [9:0] sar_ff, nxt_sar;
    logic rc_mode;
    logic step_en;
    logic [15:0] div_limit;
    logic conv_end;

    assign rc_mode = internal_rc_osc_mode | external_rc_osc_mode;

    // rate per code: base divide shifted by code, latched at start
    function automatic logic [15:0] step_div(input logic rc,
                                              input logic [1:0] code);
        logic [15:0] base;
        base = rc ? adc_ctl_pkg::RC_DIV0 : adc_ctl_pkg::XTAL_DIV0;
        return 16'(base << code);
    endfunction : step_div

    assign div_limit = step_div(rc_mode, rate_ff);
    // in rc mode the divider counts oscillator ticks, not clk_sys cycles
    assign step_en = (div_ff == div_limit - 16'h0001) & (rc_mode ? osc_tick
                                                                  : 1'b1);
    assign conv_end = step_en & (state_ff == ST_CONVERT) &
        (step_ff == adc_ctl_pkg::CONV_CYCLES - 4'h1);

    // register file
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_pin = pin_ff;
        nxt_p6_switch = p6_switch_ff;
        nxt_mask = mask_ff;
        nxt_done = done_ff;
        nxt_res_lo = res_lo_ff;
        nxt_res_hi = res_hi_ff;
        nxt_rdata = 8'h00;
        if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_PIN_SWITCH) begin
            // bits 3 and 6 are stored so their power cost stays visible
            nxt_pin = reg_wdata & adc_ctl_pkg::PIN_WMASK;
        end else if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_CONV_CTRL) begin
            nxt_ctrl = reg_wdata & adc_ctl_pkg::CTRL_WMASK;
        end else if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_RESULT_HI) begin
            nxt_p6_switch = reg_wdata[5:0];
        end else if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_IRQ_MASK) begin
            nxt_mask = reg_wdata[adc_ctl_pkg::DONE_BIT];
        end
        if (reg_wr && reg_addr == adc_ctl_pkg::ADDR_IRQ_STATUS &&
            reg_wdata[adc_ctl_pkg::DONE_BIT]) begin
            nxt_done = 1'b0;
        end
        // new value, so power and start may be written in one go
        if (!nxt_ctrl[adc_ctl_pkg::POWER_BIT]) begin
            nxt_ctrl[adc_ctl_pkg::START_BIT] = 1'b0;
        end
        if (conv_end) begin
            nxt_res_lo = nxt_sar[7:0];
            nxt_res_hi = nxt_sar[9:8];
            if (mask_ff) begin
                // set wins over a clear in the same cycle
                nxt_done = 1'b1;
                nxt_ctrl[adc_ctl_pkg::START_BIT] = 1'b0;
            end
        end
        if (!mask_ff) begin
            nxt_done = 1'b0;
        end
        if (reg_rd && reg_addr == adc_ctl_pkg::ADDR_PIN_SWITCH) begin
            nxt_rdata = pin_ff;
        end else if (reg_rd && reg_addr == adc_ctl_pkg::ADDR_CONV_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if (reg_rd && reg_addr == adc_ctl_pkg::ADDR_RESULT_LO) begin
            nxt_rdata = res_lo_ff;
        end else if (reg_rd && reg_addr == adc_ctl_pkg::ADDR_RESULT_HI) begin
            nxt_rdata = {2'b00, res_hi_ff, 4'h0} | {2'b00, p6_switch_ff};
        end else if (reg_rd && reg_addr == adc_ctl_pkg::ADDR_IRQ_STATUS) begin
            nxt_rdata = 8'(done_ff) << adc_ctl_pkg::DONE_BIT;
        end else if (reg_rd && reg_addr == adc_ctl_pkg::ADDR_IRQ_MASK) begin
            nxt_rdata = 8'(mask_ff) << adc_ctl_pkg::DONE_BIT;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_ff <= adc_ctl_pkg::CONV_CTRL_RST;
            pin_ff <= 8'h00;
            p6_switch_ff <= 6'h00;
            mask_ff <= 1'b0;
            done_ff <= 1'b0;
            res_lo_ff <= 8'h00;
            res_hi_ff <= 2'h0;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            pin_ff <= nxt_pin;
            p6_switch_ff <= nxt_p6_switch;
            mask_ff <= nxt_mask;
            done_ff <= nxt_done;
            res_lo_ff <= nxt_res_lo;
            res_hi_ff <= nxt_res_hi;
            rdata_ff <= nxt_rdata;
        end
    end

    // sequencer: sample one step, then 12 convert steps, the first 10 successive-approximation
    always_comb begin
        nxt_state = state_ff;
        nxt_chan = chan_ff;
        nxt_rate = rate_ff;
        nxt_div = step_en ? 16'h0000 :
            ((rc_mode && !osc_tick) ? div_ff : div_ff + 16'h0001);
        nxt_step = step_ff;
        nxt_sar = sar_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_div = 16'h0000;
                if (ctrl_ff[adc_ctl_pkg::START_BIT] &&
                    ctrl_ff[adc_ctl_pkg::POWER_BIT]) begin
                    nxt_state = ST_SAMPLE;
                    nxt_chan = ctrl_ff[adc_ctl_pkg::CHAN_LSB +: 3];
                    nxt_rate = ctrl_ff[adc_ctl_pkg::RATE_LSB +: 2];
                end
            end
            ST_SAMPLE: begin
                if (step_en) begin
                    nxt_state = ST_CONVERT;
                    nxt_step = 4'h0;
                    nxt_sar = 10'h200;
                end
            end
            ST_CONVERT: begin
                if (step_en && step_ff < 4'ha) begin
                    // keep trial bit if input above trial level
                    nxt_sar = sar_ff & ~(comparator_hi ? 10'h000
                        : (10'h200 >> step_ff));
                    nxt_sar = nxt_sar | ((10'h200 >> step_ff) >> 1);
                    nxt_step = step_ff + 4'h1;
                end else if (step_en) begin
                    nxt_step = step_ff + 4'h1;
                end
                if (conv_end) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (!ctrl_ff[adc_ctl_pkg::POWER_BIT]) begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            chan_ff <= 3'h0;
            rate_ff <= 2'h0;
            div_ff <= 16'h0000;
            step_ff <= 4'h0;
            sar_ff <= 10'h000;
        end else begin
            state_ff <= nxt_state;
            chan_ff <= nxt_chan;
            rate_ff <= nxt_rate;
            div_ff <= nxt_div;
            step_ff <= nxt_step;
            sar_ff <= nxt_sar;
        end
    end

    assign reg_rdata = rdata_ff;
    assign conv_power_enable = ctrl_ff[adc_ctl_pkg::POWER_BIT];
    assign mux_select = chan_ff;
    assign sample_hold = (state_ff == ST_SAMPLE);
    assign sar_trial = sar_ff;
    // order: p90,p91,p62,p63,p64,p65,p92,p93
    assign analog_pin_enable = {pin_ff[adc_ctl_pkg::CH8_BIT],
                                pin_ff[adc_ctl_pkg::CH7_BIT],
                                p6_switch_ff};
    assign irq = done_ff & mask_ff;

    // a start seen while idle and powered opens the sample window
    sample_start_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state_ff == ST_IDLE && ctrl_ff[adc_ctl_pkg::START_BIT] &&
        conv_power_enable |=> sample_hold
    ) else $error("start did not open sampling");

    start_clear_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        conv_end && mask_ff
        |=> !ctrl_ff[adc_ctl_pkg::START_BIT] && done_ff
    ) else $error("start bit not cleared at end");

    // a start bit cleared by software ends the loop, so it is left out
    cont_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        conv_end && !mask_ff && $past(mask_ff) == 1'b0 &&
        ctrl_ff[adc_ctl_pkg::START_BIT] && conv_power_enable &&
        !(reg_wr && reg_addr == adc_ctl_pkg::ADDR_CONV_CTRL)
        |=> ctrl_ff[adc_ctl_pkg::START_BIT] && !done_ff
    ) else $error("continuous mode lost start");

    done_off_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !mask_ff |=> !done_ff
    ) else $error("done set while masked");

    power_off_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !conv_power_enable |=> state_ff == ST_IDLE
    ) else $error("converter ran unpowered");

    start_gate_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !conv_power_enable |-> !ctrl_ff[adc_ctl_pkg::START_BIT]
    ) else $error("start bit kept while unpowered");

    // an interrupt edge must trace back to a completed conversion
    irq_gate_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(irq) |-> $past(conv_end) && $past(mask_ff)
    ) else $error("irq rose without an enabled completion");

    done_source_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(done_ff) |-> $past(conv_end)
    ) else $error("done flag set without completion");

    // only the first cycles are held here; the bench measures full length
    conv_len_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n || !conv_power_enable)
        $rose(state_ff == ST_CONVERT) && !rc_mode && rate_ff == 2'h0
        |-> (state_ff == ST_CONVERT)[*8]
    ) else $error("conversion ended early");

    sar_seed_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(state_ff == ST_CONVERT) |-> sar_trial == 10'h200
    ) else $error("approximation not seeded at midscale");

    chan_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state_ff != ST_IDLE && $past(state_ff) != ST_IDLE
        |-> $stable(chan_ff) && $stable(rate_ff)
    ) else $error("channel changed mid conversion");

    mux_latch_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(sample_hold)
        |-> mux_select == $past(ctrl_ff[adc_ctl_pkg::CHAN_LSB +: 3])
    ) else $error("channel not taken at start");

    result_store_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        conv_end |=> res_lo_ff == $past(sar_ff[7:0]) &&
        res_hi_ff == $past(sar_ff[9:8])
    ) else $error("result not stored");

    ch7_pin_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == adc_ctl_pkg::ADDR_PIN_SWITCH
        |=> analog_pin_enable[7:6] == $past(reg_wdata[1:0])
    ) else $error("pin switch not applied");

    p6_pin_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == adc_ctl_pkg::ADDR_RESULT_HI
        |=> analog_pin_enable[5:0] == $past(reg_wdata[5:0])
    ) else $error("shared pin switch not applied");

    // read data stands for one cycle only, so stale values never leak
    rdata_pulse_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !$past(reg_rd) |-> reg_rdata == 8'h00
    ) else $error("read data outside its cycle");
endmodule : adc_conversion_control

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic internal_rc_osc_mode = 1'b0;
    logic external_rc_osc_mode = 1'b0;
    logic osc_tick = 1'b0;
    logic conv_power_enable;
    logic [2:0] mux_select;
    logic sample_hold;
    logic [9:0] sar_trial;
    logic comparator_hi = 1'b0;
    logic [7:0] analog_pin_enable;
    logic irq;
    logic [9:0] level = 10'h000;
    int failures = 0;
    int cmp_count = 0;
    int n0;
    int n1;
    always #12.5 clk_sys = ~clk_sys;
    // one cycle of comparator lag is far below one approximation step
    always @(posedge clk_sys) begin
        comparator_hi <= (sar_trial <= level);
        osc_tick <= ~osc_tick;
    end
    adc_conversion_control u_adc_conversion_control (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .internal_rc_osc_mode(internal_rc_osc_mode),
        .external_rc_osc_mode(external_rc_osc_mode),
        .osc_tick(osc_tick), .conv_power_enable(conv_power_enable),
        .mux_select(mux_select), .sample_hold(sample_hold),
        .sar_trial(sar_trial), .comparator_hi(comparator_hi),
        .analog_pin_enable(analog_pin_enable), .irq(irq)
    );
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(16'(reg_rdata), 16'(exp));
    endtask : rd_chk
    // start a conversion and count cycles until the interrupt shows
    task automatic conv(input logic [7:0] ctrl, output int n);
        wr(adc_ctl_pkg::ADDR_IRQ_STATUS, 8'h20);
        wr(adc_ctl_pkg::ADDR_CONV_CTRL, ctrl);
        n = 0;
        while (irq !== 1'b1 && n < 4000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 4000) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, irq, 1'b1);
            end_of_test();
        end
    endtask : conv
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(adc_ctl_pkg::ADDR_CONV_CTRL, adc_ctl_pkg::CONV_CTRL_RST);
        check(16'({irq, conv_power_enable, analog_pin_enable}), 16'h0000);
        $display("test reset done");
        wr(adc_ctl_pkg::ADDR_PIN_SWITCH, 8'hff);
        rd_chk(adc_ctl_pkg::ADDR_PIN_SWITCH, adc_ctl_pkg::PIN_WMASK);
        check(16'(analog_pin_enable[7:6]), 16'h0003);
        wr(adc_ctl_pkg::ADDR_RESULT_HI, 8'h3f);
        check(16'(analog_pin_enable), 16'h00ff);
        wr(adc_ctl_pkg::ADDR_PIN_SWITCH, 8'h01);
        wr(adc_ctl_pkg::ADDR_RESULT_HI, 8'h05);
        check(16'(analog_pin_enable), 16'h0045);
        wr(adc_ctl_pkg::ADDR_CONV_CTRL, 8'h02);
        rd_chk(adc_ctl_pkg::ADDR_CONV_CTRL, 8'h00);
        rd_chk(3'h6, 8'h00);
        $display("test pin switches done");
        wr(adc_ctl_pkg::ADDR_IRQ_MASK, 8'h20);
        level = 10'h2a5;
        wr(adc_ctl_pkg::ADDR_CONV_CTRL, 8'hc5);
        check(16'(conv_power_enable), 16'h0001);
        repeat (3) @(posedge clk_sys);
        check(16'(mux_select), 16'h0006);
        wr(adc_ctl_pkg::ADDR_CONV_CTRL, 8'h45);
        repeat (2) @(posedge clk_sys);
        check(16'(mux_select), 16'h0006);
        conv(8'h45, n0);
        rd_chk(adc_ctl_pkg::ADDR_RESULT_LO, 8'ha5);
        rd_chk(adc_ctl_pkg::ADDR_RESULT_HI, 8'h25);
        rd_chk(adc_ctl_pkg::ADDR_CONV_CTRL, 8'h44);
        rd_chk(adc_ctl_pkg::ADDR_IRQ_STATUS, 8'h20);
        wr(adc_ctl_pkg::ADDR_IRQ_STATUS, 8'h20);
        repeat (2) @(posedge clk_sys);
        check(16'(irq), 16'h0000);
        $display("test conversion done");
        level = 10'h155;
        conv(8'h05, n0);
        conv(8'h0d, n1);
        check(16'(n0 >= 12 * adc_ctl_pkg::XTAL_DIV0 &&
                  n0 <= 13 * adc_ctl_pkg::XTAL_DIV0 + 8), 16'h0001);
        check(16'(n1 >= 2 * n0 - 8 && n1 <= 2 * n0 + 8), 16'h0001);
        rd_chk(adc_ctl_pkg::ADDR_RESULT_LO, 8'h55);
        $display("test crystal rate done");
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys);
            internal_rc_osc_mode <= (m == 0);
            external_rc_osc_mode <= (m == 1);
            // osc_tick is high every second clock
            conv(8'h05, n0);
            conv(8'h0d, n1);
            check(16'(n0 >= 96 && n0 <= 112), 16'h0001);
            check(16'(n1 >= 2 * n0 - 8 && n1 <= 2 * n0 + 8), 16'h0001);
        end
        $display("test rc rate done");
        wr(adc_ctl_pkg::ADDR_IRQ_MASK, 8'h00);
        wr(adc_ctl_pkg::ADDR_IRQ_STATUS, 8'h20);
        wr(adc_ctl_pkg::ADDR_CONV_CTRL, 8'h05);
        n0 = 0;
        repeat (600) begin
            @(posedge clk_sys);
            n0 += int'(sample_hold);
        end
        check(16'(n0 >= 32), 16'h0001);
        rd_chk(adc_ctl_pkg::ADDR_CONV_CTRL, 8'h05);
        rd_chk(adc_ctl_pkg::ADDR_IRQ_STATUS, 8'h00);
        check(16'(irq), 16'h0000);
        wr(adc_ctl_pkg::ADDR_CONV_CTRL, 8'h00);
        rd_chk(adc_ctl_pkg::ADDR_CONV_CTRL, 8'h00);
        check(16'(conv_power_enable), 16'h0000);
        $display("test continuous done");
        end_of_test();
    end
endmodule : tb
